// File: rtl/servo_pkg.sv
// Package with constants and types for the servo offset and fault action block
package servo_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_FAULTS = 6;
  localparam logic [DATA_W-1:0] FULL_SCALE = 16'h7fff;
  localparam logic [DATA_W-1:0] NEG_FULL_SCALE = 16'h8001;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FRICTION = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_VEL_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TRQ_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_OUT_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ACTIONS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PERR_TOL = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_MAX_POS = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_MAX_NEG = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_MAX_DECEL = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_CLR = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h38;

  localparam int CTRL_SOFT_OT_EN = 0;
  localparam int CTRL_HOMED = 1;

  localparam int FLT_SOFT_OT = 0;
  localparam int FLT_HARD_OT = 1;
  localparam int FLT_POS_ERR = 2;
  localparam int FLT_FEEDBACK = 3;
  localparam int FLT_FB_NOISE = 4;
  localparam int FLT_DRIVE = 5;

  localparam logic [11:0] ACTIONS_RESET = 12'h000;

  typedef enum logic [1:0] {
    ACT_SHUTDOWN = 2'h0,
    ACT_DISABLE  = 2'h1,
    ACT_STOP     = 2'h2,
    ACT_STATUS   = 2'h3
  } action_t;

  typedef enum {ST_RUN, ST_STOPPING, ST_HALTED, ST_DISABLED} axis_state_t;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } bus_req_t;

  typedef struct packed {
    logic signed [DATA_W-1:0] vel_cmd;
    logic signed [DATA_W-1:0] trq_cmd;
    logic signed [DATA_W-1:0] servo_out;
    logic signed [DATA_W-1:0] pos_err;
    logic signed [DATA_W-1:0] position;
  } loop_in_t;
endpackage

// File: rtl/servo_offset_fault_action.sv
// Servo output conditioning and fault action logic for one axis
// Summary of operation
// - Add friction level to positive output, subtract it from negative output.
// - Friction compensation only while position error is non-zero.
// - Add velocity offset to position loop velocity command.
// - Add torque offset, clamped to full rated torque, to torque command.
// - Velocity and torque offsets take effect only on the coarse update tick.
// - Add signed output offset within ten volts to servo output.
// - Six fault sources each have a two bit action selector.
// - Disable drive action zeroes command output and drops drive enable.
// - Shutdown does disable drive and also opens the OK contact.
// - Stop command ramps command to rest at max deceleration, drive enabled.
// - After stop action halts axis, motion requests are rejected until cleared.
// - Status only action just reports; software decides the response.
// - Position error fault when error magnitude exceeds tolerance either way.
// - Soft overtravel fault when enabled, homed and position beyond limits.
`timescale 1ns/1ns
module servo_offset_fault_action #(
  parameter int DW = servo_pkg::DATA_W
) (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        tick_in,
  input  wire servo_pkg::bus_req_t         bus_in,
  input  wire servo_pkg::loop_in_t         loop_in,
  input  wire logic signed [DW-1:0]        cmd_vel_in,
  input  wire logic                        move_req_in,
  input  wire logic                        hard_ot_in,
  input  wire logic                        feedback_flt_in,
  input  wire logic                        fb_noise_in,
  input  wire logic                        drive_flt_in,
  output logic [31:0]                      rdata_out,
  output logic signed [DW-1:0]             vel_cmd_out,
  output logic signed [DW-1:0]             trq_cmd_out,
  output logic signed [DW-1:0]             amp_cmd_out,
  output logic signed [DW-1:0]             ramp_vel_out,
  output logic                             drive_en_out,
  output logic                             ok_contact_out,
  output logic                             move_accept_out,
  output logic                             irq_out
);

  function automatic logic signed [DW-1:0] sat_add(input logic signed [DW-1:0] a,
                                                   input logic signed [DW-1:0] b);
    logic signed [DW:0] s;
    s = {a[DW-1], a} + {b[DW-1], b};
    if (s > $signed({1'b0, servo_pkg::FULL_SCALE}))
      sat_add = servo_pkg::FULL_SCALE;
    else if (s < $signed({1'b1, servo_pkg::NEG_FULL_SCALE}))
      sat_add = servo_pkg::NEG_FULL_SCALE;
    else
      sat_add = s[DW-1:0];
  endfunction

  function automatic logic [1:0] rank(input logic [1:0] act);
    rank = act;
  endfunction

  logic [1:0]               ctrl;
  logic signed [DW-1:0]     friction;
  logic signed [DW-1:0]     vel_offset;
  logic signed [DW-1:0]     trq_offset;
  logic signed [DW-1:0]     out_offset;
  logic [11:0]              actions;
  logic signed [DW-1:0]     perr_tol;
  logic signed [DW-1:0]     max_pos;
  logic signed [DW-1:0]     max_neg;
  logic [DW-1:0]            max_decel;
  logic signed [DW-1:0]     vel_offset_live;
  logic signed [DW-1:0]     trq_offset_live;
  logic [5:0]               fault_flag;
  logic [5:0]               irq_stat;
  logic [5:0]               irq_mask;
  logic signed [DW-1:0]     ramp_vel;
  servo_pkg::axis_state_t   state;
  servo_pkg::axis_state_t   next_state;

  wire wr = bus_in.write;
  wire rd = bus_in.read;
  wire [servo_pkg::ADDR_W-1:0] addr = bus_in.addr;
  wire [DW-1:0] wd = bus_in.wdata[DW-1:0];

  wire signed [DW-1:0] perr = loop_in.pos_err;
  wire signed [DW-1:0] pos = loop_in.position;
  wire signed [DW-1:0] neg_tol = -perr_tol;
  wire perr_fault = (perr > perr_tol) || (perr < neg_tol);
  wire soft_ot = ctrl[servo_pkg::CTRL_SOFT_OT_EN] && ctrl[servo_pkg::CTRL_HOMED]
                 && ((pos > max_pos) || (pos < max_neg));
  wire [5:0] fault_now = {drive_flt_in, fb_noise_in, feedback_flt_in,
                          perr_fault, hard_ot_in, soft_ot};
  wire [5:0] fault_rise = fault_now & ~fault_flag;
  wire clr_wr = wr && (addr == servo_pkg::ADDR_FAULT_CLR);
  wire [5:0] next_fault_flag = fault_now | (fault_flag & ~(clr_wr ? wd[5:0] : 6'h00));

  logic [1:0] worst;
  always_comb begin
    worst = servo_pkg::ACT_STATUS;
    for (int i = 0; i < servo_pkg::NUM_FAULTS; i++) begin
      if (fault_flag[i] && rank(actions[2*i +: 2]) < rank(worst)) begin
        worst = actions[2*i +: 2];
      end
    end
  end
  wire shutdown = (worst == servo_pkg::ACT_SHUTDOWN);
  wire disable_drv = shutdown || (worst == servo_pkg::ACT_DISABLE);
  wire stop_cmd = (worst == servo_pkg::ACT_STOP);

  wire signed [DW-1:0] decel = $signed(max_decel);
  wire ramp_done = (ramp_vel <= decel) && (ramp_vel >= -decel);
  wire signed [DW-1:0] next_ramp = ramp_done ? '0
                                   : (ramp_vel > 0 ? ramp_vel - decel : ramp_vel + decel);

  always_comb begin
    next_state = state;
    case (state)
      servo_pkg::ST_RUN: begin
        if (disable_drv) next_state = servo_pkg::ST_DISABLED;
        else if (stop_cmd) next_state = servo_pkg::ST_STOPPING;
      end
      servo_pkg::ST_STOPPING: begin
        if (disable_drv) next_state = servo_pkg::ST_DISABLED;
        else if (tick_in && ramp_done) next_state = servo_pkg::ST_HALTED;
      end
      servo_pkg::ST_HALTED: begin
        if (disable_drv) next_state = servo_pkg::ST_DISABLED;
        else if (fault_flag == 6'h00) next_state = servo_pkg::ST_RUN;
      end
      servo_pkg::ST_DISABLED: begin
        if (!disable_drv && !stop_cmd) next_state = servo_pkg::ST_RUN;
        else if (!disable_drv) next_state = servo_pkg::ST_HALTED;
      end
      default: next_state = servo_pkg::ST_RUN;
    endcase
  end

  wire signed [DW-1:0] trq_off_cl = (wd[DW-1] == 1'b0) ? $signed(wd)
                                    : (($signed(wd) < $signed(servo_pkg::NEG_FULL_SCALE))
                                       ? $signed(servo_pkg::NEG_FULL_SCALE) : $signed(wd));
  wire signed [DW-1:0] fric_cl = wd[DW-1] ? '0 : $signed(wd);
  wire signed [DW-1:0] so = loop_in.servo_out;
  wire signed [DW-1:0] fric_term = (perr == '0 || so == '0) ? '0
                                   : (so > 0 ? friction : -friction);
  wire signed [DW-1:0] amp_next = sat_add(sat_add(so, fric_term), out_offset);
  wire servo_off = (state == servo_pkg::ST_DISABLED) || disable_drv;

  wire [31:0] rd_mux =
      addr == servo_pkg::ADDR_CTRL       ? {30'h0, ctrl} :
      addr == servo_pkg::ADDR_FRICTION   ? {{16{1'b0}}, friction} :
      addr == servo_pkg::ADDR_VEL_OFFSET ? {{16{1'b0}}, vel_offset} :
      addr == servo_pkg::ADDR_TRQ_OFFSET ? {{16{1'b0}}, trq_offset} :
      addr == servo_pkg::ADDR_OUT_OFFSET ? {{16{1'b0}}, out_offset} :
      addr == servo_pkg::ADDR_ACTIONS    ? {20'h0, actions} :
      addr == servo_pkg::ADDR_PERR_TOL   ? {{16{1'b0}}, perr_tol} :
      addr == servo_pkg::ADDR_MAX_POS    ? {{16{1'b0}}, max_pos} :
      addr == servo_pkg::ADDR_MAX_NEG    ? {{16{1'b0}}, max_neg} :
      addr == servo_pkg::ADDR_MAX_DECEL  ? {{16{1'b0}}, max_decel} :
      addr == servo_pkg::ADDR_FAULT_STAT ? {26'h0, fault_flag} :
      addr == servo_pkg::ADDR_IRQ_STAT   ? {26'h0, irq_stat} :
      addr == servo_pkg::ADDR_IRQ_MASK   ? {26'h0, irq_mask} :
      addr == servo_pkg::ADDR_STATE      ? {28'h0, 2'(state), worst} : 32'h0;

  wire irq_rd = rd && (addr == servo_pkg::ADDR_IRQ_STAT);
  wire [5:0] next_irq_stat = fault_rise | (irq_rd ? 6'h00 : irq_stat);

  // Register write selects
  wire sel_ctrl  = wr && (addr == servo_pkg::ADDR_CTRL);
  wire sel_fric  = wr && (addr == servo_pkg::ADDR_FRICTION);
  wire sel_vel   = wr && (addr == servo_pkg::ADDR_VEL_OFFSET);
  wire sel_trq   = wr && (addr == servo_pkg::ADDR_TRQ_OFFSET);
  wire sel_out   = wr && (addr == servo_pkg::ADDR_OUT_OFFSET);
  wire sel_act   = wr && (addr == servo_pkg::ADDR_ACTIONS);
  wire sel_tol   = wr && (addr == servo_pkg::ADDR_PERR_TOL);
  wire sel_maxp  = wr && (addr == servo_pkg::ADDR_MAX_POS);
  wire sel_maxn  = wr && (addr == servo_pkg::ADDR_MAX_NEG);
  wire sel_decel = wr && (addr == servo_pkg::ADDR_MAX_DECEL);
  wire sel_mask  = wr && (addr == servo_pkg::ADDR_IRQ_MASK);

  // Stop ramp steps on ticks and holds its value once halted
  wire signed [DW-1:0] next_ramp_vel =
      (state == servo_pkg::ST_STOPPING) ? (tick_in ? next_ramp : ramp_vel) :
      (state == servo_pkg::ST_HALTED)   ? ramp_vel : cmd_vel_in;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) ctrl <= 2'h0;
    else if (sel_ctrl) ctrl <= wd[1:0];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) friction <= '0;
    else if (sel_fric) friction <= fric_cl;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) vel_offset <= '0;
    else if (sel_vel) vel_offset <= $signed(wd);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) trq_offset <= '0;
    else if (sel_trq) trq_offset <= trq_off_cl;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) out_offset <= '0;
    else if (sel_out) out_offset <= $signed(wd);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) actions <= servo_pkg::ACTIONS_RESET;
    else if (sel_act) actions <= bus_in.wdata[11:0];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) perr_tol <= servo_pkg::FULL_SCALE;
    else if (sel_tol) perr_tol <= fric_cl;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) max_pos <= servo_pkg::FULL_SCALE;
    else if (sel_maxp) max_pos <= $signed(wd);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) max_neg <= servo_pkg::NEG_FULL_SCALE;
    else if (sel_maxn) max_neg <= $signed(wd);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) max_decel <= 16'h0001;
    else if (sel_decel) max_decel <= wd;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) irq_mask <= 6'h00;
    else if (sel_mask) irq_mask <= wd[5:0];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      vel_offset_live <= '0;
      trq_offset_live <= '0;
      fault_flag      <= 6'h00;
      irq_stat        <= 6'h00;
      state           <= servo_pkg::ST_RUN;
      ramp_vel        <= '0;
    end else begin
      if (tick_in) begin
        vel_offset_live <= vel_offset;
        trq_offset_live <= trq_offset;
      end
      fault_flag <= next_fault_flag;
      irq_stat   <= next_irq_stat;
      state      <= next_state;
      ramp_vel   <= next_ramp_vel;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) rdata_out <= 32'h0;
    else rdata_out <= rd ? rd_mux : 32'h0;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) vel_cmd_out <= '0;
    else vel_cmd_out <= servo_off ? '0 : sat_add(loop_in.vel_cmd, vel_offset_live);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) trq_cmd_out <= '0;
    else trq_cmd_out <= servo_off ? '0 : sat_add(loop_in.trq_cmd, trq_offset_live);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) amp_cmd_out <= '0;
    else amp_cmd_out <= servo_off ? '0 : amp_next;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) ramp_vel_out <= '0;
    else ramp_vel_out <= next_ramp_vel;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) drive_en_out <= 1'b0;
    else drive_en_out <= !servo_off;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) ok_contact_out <= 1'b0;
    else ok_contact_out <= !shutdown;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) move_accept_out <= 1'b0;
    else move_accept_out <= move_req_in && (state == servo_pkg::ST_RUN) && !stop_cmd
                            && !servo_off;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) irq_out <= 1'b0;
    else irq_out <= |(next_irq_stat & irq_mask);
  end

endmodule

// File: test/servo_drive_model.sv
// Model of the external servo drive and its supply stop chain
`timescale 1ns/1ns
module servo_drive_model (
  input  wire logic clock_in,
  input  wire logic drive_en_in,
  input  wire logic ok_contact_in,
  input  wire logic fault_cmd_in,
  output logic      drive_flt_out,
  output logic      powered_out
);
  // Drive reports a fault only when the bench asks; it takes no action of its own
  assign drive_flt_out = fault_cmd_in;
  // Supply string follows the OK contact
  always_ff @(posedge clock_in) begin
    powered_out <= ok_contact_in;
  end
endmodule

// File: test/servo_offset_fault_action_monitor.sv
// Assertion checker for the servo offset and fault action block
`timescale 1ns/1ns
module servo_monitor #(
  parameter int DW = servo_pkg::DATA_W
) (
  input wire logic                clock_in,
  input wire logic                rst_n_in,
  input wire logic                tick_in,
  input wire servo_pkg::bus_req_t bus_in,
  input wire servo_pkg::loop_in_t loop_in,
  input wire logic                move_req_in,
  input wire logic [31:0]         rdata_out,
  input wire logic signed [DW-1:0] vel_cmd_out,
  input wire logic signed [DW-1:0] trq_cmd_out,
  input wire logic signed [DW-1:0] amp_cmd_out,
  input wire logic                drive_en_out,
  input wire logic                ok_contact_out,
  input wire logic                move_accept_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_off_zero_cmd: assert property (
    !drive_en_out |-> amp_cmd_out == 0 && vel_cmd_out == 0 && trq_cmd_out == 0)
    else $error("command not zero with drive off");
  chk_open_means_off: assert property (
    !ok_contact_out |-> !drive_en_out) else $error("contact open with drive on");
  chk_accept_needs_req: assert property (
    move_accept_out |-> $past(move_req_in)) else $error("accept without request");
  chk_accept_drive_on: assert property (
    move_accept_out |-> drive_en_out) else $error("accept with drive off");
  chk_offset_on_tick: assert property (
    (!tick_in && $stable(loop_in) && drive_en_out)[*3] |->
      $stable(vel_cmd_out) && $stable(trq_cmd_out)) else $error("offset moved off tick");
  chk_rdata_idle: assert property (
    !$past(bus_in.read) |-> rdata_out == 32'h0) else $error("read data without read");
  chk_amp_sat: assert property (
    amp_cmd_out != 16'h8000) else $error("amplifier command beyond range");
  chk_vel_sat: assert property (
    vel_cmd_out != 16'h8000) else $error("velocity command beyond range");
endmodule
bind servo_offset_fault_action servo_monitor #(.DW(DW)) u_mon (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .tick_in(tick_in), .bus_in(bus_in),
  .loop_in(loop_in), .move_req_in(move_req_in), .rdata_out(rdata_out),
  .vel_cmd_out(vel_cmd_out), .trq_cmd_out(trq_cmd_out), .amp_cmd_out(amp_cmd_out),
  .drive_en_out(drive_en_out), .ok_contact_out(ok_contact_out),
  .move_accept_out(move_accept_out));

// File: test/tb_servo_offset_fault_action.sv
// Testbench for the servo offset and fault action block
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_servo_offset_fault_action;
  logic                clock_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic                tick_in = 1'b0;
  servo_pkg::bus_req_t bus_in = '0;
  servo_pkg::loop_in_t loop_in = '0;
  logic signed [15:0]  cmd_vel_in = '0;
  logic                move_req_in = 1'b0;
  logic                hard_ot_in = 1'b0;
  logic                fault_cmd = 1'b0;
  logic                drive_flt, powered, drive_en_out, ok_contact_out, move_accept_out, irq_out;
  logic [31:0]         rdata_out;
  logic signed [15:0]  vel_cmd_out, trq_cmd_out, amp_cmd_out, ramp_vel_out, v;
  logic signed [15:0]  sv [4] = '{16'sh100, -16'sh100, 16'sh7ff0, 16'sh0};
  int                  comparisons = 0;
  int                  miscompares = 0;
  always #5 clock_in = ~clock_in;
  servo_offset_fault_action dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .tick_in(tick_in),
    .bus_in(bus_in), .loop_in(loop_in), .cmd_vel_in(cmd_vel_in), .move_req_in(move_req_in),
    .hard_ot_in(hard_ot_in), .feedback_flt_in(1'b0), .fb_noise_in(1'b0),
    .drive_flt_in(drive_flt), .rdata_out(rdata_out), .vel_cmd_out(vel_cmd_out),
    .trq_cmd_out(trq_cmd_out), .amp_cmd_out(amp_cmd_out), .ramp_vel_out(ramp_vel_out),
    .drive_en_out(drive_en_out), .ok_contact_out(ok_contact_out),
    .move_accept_out(move_accept_out), .irq_out(irq_out));
  servo_drive_model drv_u (.clock_in(clock_in), .drive_en_in(drive_en_out),
    .ok_contact_in(ok_contact_out), .fault_cmd_in(fault_cmd), .drive_flt_out(drive_flt),
    .powered_out(powered));
  task cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus_in <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    bus_in <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    bus_in <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_in);
    bus_in <= '0;
    #1;
    `CHK(rdata_out, e)
  endtask
  task tick;
    @(posedge clock_in);
    tick_in <= 1'b1;
    @(posedge clock_in);
    tick_in <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] amp_exp(int s, int p);
    int r;
    r = s + ((p != 0 && s != 0) ? ((s > 0) ? 32'sh20 : -32'sh20) : 0) + 32'sh10;
    r = (r > 32767) ? 32767 : ((r < -32767) ? -32767 : r);
    return r[15:0];
  endfunction
  task summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    cyc(3);
    `CHK({drive_en_out, ok_contact_out}, 2'b11)
    rd(servo_pkg::ADDR_ACTIONS, 32'h0);
    rd(servo_pkg::ADDR_PERR_TOL, 32'h7fff);
    rd(8'h3c, 32'h0);
    wr(servo_pkg::ADDR_ACTIONS, 32'hfff);
    wr(servo_pkg::ADDR_IRQ_MASK, 32'h3f);
    loop_in.vel_cmd <= 16'sd100;
    loop_in.trq_cmd <= 16'sd50;
    wr(servo_pkg::ADDR_VEL_OFFSET, 32'h5);
    wr(servo_pkg::ADDR_TRQ_OFFSET, 32'hfffb);
    cyc(2);
    `CHK({vel_cmd_out, trq_cmd_out}, {16'sd100, 16'sd50})
    tick();
    cyc(2);
    `CHK({vel_cmd_out, trq_cmd_out}, {16'sd105, 16'sd45})
    wr(servo_pkg::ADDR_TRQ_OFFSET, 32'h8000);
    tick();
    cyc(2);
    `CHK(trq_cmd_out, 16'h8033)
    wr(servo_pkg::ADDR_FRICTION, 32'h20);
    wr(servo_pkg::ADDR_OUT_OFFSET, 32'h10);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      loop_in.servo_out <= sv[i/2];
      loop_in.pos_err <= 16'(i % 2);
      cyc(3);
      `CHK(amp_cmd_out, amp_exp(sv[i/2], i % 2))
    end
    cmd_vel_in <= 16'sd10;
    wr(servo_pkg::ADDR_MAX_DECEL, 32'h3);
    for (int a = 0; a < 4; a++) begin
      wr(servo_pkg::ADDR_ACTIONS, {20'h0, 2'(a), 10'h3ff});
      @(posedge clock_in);
      fault_cmd <= 1'b1;
      move_req_in <= 1'b1;
      cyc(3);
      `CHK({drive_en_out, ok_contact_out, powered}, {1'(a >= 2), 1'(a != 0), 1'(a != 0)})
      `CHK(irq_out, 1'b1)
      v = 16'sd10;
      for (int k = 0; k < 4 && a == 2; k++) begin
        tick();
        v = (v > 3) ? v - 16'sd3 : 16'sd0;
        `CHK(ramp_vel_out, v)
      end
      cyc(2);
      if (a == 2) `CHK(move_accept_out, 1'b0)
      @(posedge clock_in);
      fault_cmd <= 1'b0;
      cyc(2);
      rd(servo_pkg::ADDR_FAULT_STAT, 32'h20);
      wr(servo_pkg::ADDR_FAULT_CLR, 32'h3f);
      rd(servo_pkg::ADDR_IRQ_STAT, 32'h20);
      rd(servo_pkg::ADDR_FAULT_STAT, 32'h0);
      cyc(3);
      `CHK({drive_en_out, ok_contact_out, irq_out}, 3'b110)
      if (a == 2) `CHK(move_accept_out, 1'b1)
      @(posedge clock_in);
      move_req_in <= 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      wr(servo_pkg::ADDR_ACTIONS, (j == 0) ? 32'h7ff : 32'h3fb);
      @(posedge clock_in);
      fault_cmd <= 1'b1;
      hard_ot_in <= 1'b1;
      cyc(3);
      `CHK({drive_en_out, ok_contact_out}, {1'b0, 1'(j == 0)})
      @(posedge clock_in);
      fault_cmd <= 1'b0;
      hard_ot_in <= 1'b0;
      wr(servo_pkg::ADDR_FAULT_CLR, 32'h3f);
    end
    wr(servo_pkg::ADDR_ACTIONS, 32'hfff);
    wr(servo_pkg::ADDR_PERR_TOL, 32'h10);
    wr(servo_pkg::ADDR_MAX_POS, 32'h100);
    wr(servo_pkg::ADDR_CTRL, 32'h3);
    loop_in.pos_err <= 16'sh10;
    loop_in.position <= 16'sh100;
    cyc(3);
    rd(servo_pkg::ADDR_FAULT_STAT, 32'h0);
    loop_in.pos_err <= -16'sh11;
    loop_in.position <= 16'sh101;
    cyc(3);
    rd(servo_pkg::ADDR_FAULT_STAT, 32'h5);
    summarize();
  end
endmodule
